// File: design/gic_defs.svh
// Offsets, write masks, reset values and timing counts for the pin and I2C setup block
// Function
// - Local value driven only for output, local control
// - Cleared enable tri-states the pin
// - Far control makes pin output far value
// - Far values ignored when far control off
// - SDA delay grows 50 ns per code step
// - SDA delay 350/400/450/500 ns, reset code 00
// - Block far-side writes to own registers
// - Far transactions to local slaves still pass
// - Watchdog expiry 50 us fast, 1 s slow
// - Disable bit stops the watchdog
// - Expiry with SDA high marks bus free
// - Expiry with SDA low sends nine SCL pulses
`ifndef GIC_DEFS_SVH
`define GIC_DEFS_SVH

`define GIC_ADDR_PINS 8'h0E
`define GIC_ADDR_I2C 8'h0F
`define GIC_PINS_RESET 8'h35
`define GIC_I2C_RESET 8'h00
`define GIC_PINS_WMASK 8'hFD
`define GIC_I2C_WMASK 8'h1F

`define GIC_CLK_MHZ 100
`define GIC_WD_FAST_US 50
`define GIC_WD_SLOW_S 1
`define GIC_WD_FAST_CYC (`GIC_WD_FAST_US * `GIC_CLK_MHZ)
`define GIC_WD_SLOW_CYC (`GIC_WD_SLOW_S * 1000000 * `GIC_CLK_MHZ)
`define GIC_SDA_BASE_NS 350
`define GIC_SDA_STEP_NS 50
`define GIC_SDA_BASE_CYC (`GIC_SDA_BASE_NS * `GIC_CLK_MHZ / 1000)
`define GIC_SDA_STEP_CYC (`GIC_SDA_STEP_NS * `GIC_CLK_MHZ / 1000)
`define GIC_SCL_HALF_NS 1250
`define GIC_SCL_HALF_CYC (`GIC_SCL_HALF_NS * `GIC_CLK_MHZ / 1000)
`define GIC_RECOVER_PULSES 9

`endif

// File: design/gic_gpio_i2c_cfg.sv
// Pin pair setup, I2C master setup and bus watchdog with recovery
`timescale 1ns/1ps
`include "gic_defs.svh"
module gic_gpio_i2c_cfg #(
  parameter int WD_FAST = `GIC_WD_FAST_CYC,
  parameter int WD_SLOW = `GIC_WD_SLOW_CYC,
  parameter int SCL_HALF = `GIC_SCL_HALF_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire gic_pkg::gic_req_t req,
  output logic [7:0] regRdData,
  output logic regWrRejected,
  input wire logic [1:0] farPinVal,
  output logic [1:0] pinOut,
  output logic [1:0] pinOe,
  input wire logic farSlaveReq,
  output logic farSlaveFwd,
  input wire logic mstSdaLow,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe,
  output logic busFree
);
  import gic_pkg::*;

  localparam int CW = $clog2(WD_SLOW + 1);
  localparam int HW = $clog2(SCL_HALF + 1);

  gic_pins_t pinCfg, next_pinCfg;
  gic_i2c_t setup, next_setup;
  logic [7:0] next_regRdData;
  logic next_regWrRejected;

  // Register file
  always_comb begin
    next_pinCfg = pinCfg;
    next_setup = setup;
    next_regRdData = regRdData;
    next_regWrRejected = 1'b0;
    if (req.wr) begin
      if (req.far && setup.blockFarWr) begin
        next_regWrRejected = 1'b1;
      end else if (req.addr == `GIC_ADDR_PINS) begin
        next_pinCfg = gic_pins_t'(req.wrData & `GIC_PINS_WMASK);
      end else if (req.addr == `GIC_ADDR_I2C) begin
        next_setup = gic_i2c_t'(req.wrData & `GIC_I2C_WMASK);
      end
    end
    if (req.rd) begin
      if (req.addr == `GIC_ADDR_PINS) begin
        next_regRdData = pinCfg & `GIC_PINS_WMASK;
      end else if (req.addr == `GIC_ADDR_I2C) begin
        next_regRdData = setup & `GIC_I2C_WMASK;
      end else begin
        next_regRdData = 8'h00;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pinCfg <= gic_pins_t'(`GIC_PINS_RESET);
      setup <= gic_i2c_t'(`GIC_I2C_RESET);
      regRdData <= 8'h00;
      regWrRejected <= 1'b0;
    end else begin
      pinCfg <= next_pinCfg;
      setup <= next_setup;
      regRdData <= next_regRdData;
      regWrRejected <= next_regWrRejected;
    end
  end

  // Pin drivers; pin two has no direction field and is an output whenever p2En is set
  logic [1:0] next_pinOut, next_pinOe;
  logic next_farSlaveFwd;

  always_comb begin
    next_farSlaveFwd = farSlaveReq;
    next_pinOe[0] = pinCfg.p2En;
    if (pinCfg.pin_two_far_ctrl) begin
      next_pinOut[0] = farPinVal[0];
    end else begin
      next_pinOut[0] = pinCfg.p2Val;
    end
    if (pinCfg.pin_three_far_ctrl) begin
      next_pinOe[1] = pinCfg.p3En;
      next_pinOut[1] = farPinVal[1];
    end else begin
      next_pinOe[1] = pinCfg.p3En && !pinCfg.pin_three_dir;
      next_pinOut[1] = pinCfg.p3Val;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pinOut <= 2'b00;
      pinOe <= 2'b00;
      farSlaveFwd <= 1'b0;
    end else begin
      pinOut <= next_pinOut;
      pinOe <= next_pinOe;
      farSlaveFwd <= next_farSlaveFwd;
    end
  end

  // SDA output delay
  logic sdaDelayed;
  logic next_sdaOe;

  gic_sda_delay #(
    .BASE(`GIC_SDA_BASE_CYC),
    .STEP(`GIC_SDA_STEP_CYC)
  ) u_sda_delay (
    .clock(clock),
    .rstn(rstn),
    .din(mstSdaLow),
    .sel(setup.sdaDelay),
    .dout(sdaDelayed)
  );

  always_comb begin
    next_sdaOe = sdaDelayed;
  end

  // Watchdog and bus recovery
  gic_rec_t state, next_state;
  logic [CW-1:0] wdCnt, next_wdCnt;
  logic [HW-1:0] halfCnt, next_halfCnt;
  logic [3:0] pulseCnt, next_pulseCnt;
  logic sclPrev, sdaPrev, activity, wdExpire;
  logic next_sclOe, next_busFree;
  logic [CW-1:0] wdLimit;

  always_comb begin
    activity = (sclIn != sclPrev) || (sdaIn != sdaPrev);
    wdLimit = setup.wdFast ? CW'(WD_FAST - 1) : CW'(WD_SLOW - 1);
    wdExpire = !setup.wdOff && state == REC_IDLE && !activity
      && wdCnt == wdLimit;
    next_state = state;
    next_wdCnt = wdCnt;
    next_halfCnt = halfCnt;
    next_pulseCnt = pulseCnt;
    next_busFree = busFree;
    if (activity) begin
      next_busFree = 1'b0;
    end
    if (setup.wdOff || activity || state != REC_IDLE || wdExpire) begin
      next_wdCnt = '0;
    end else begin
      next_wdCnt = wdCnt + CW'(1);
    end
    unique case (state)
      REC_IDLE: begin
        next_halfCnt = '0;
        next_pulseCnt = 4'h0;
        if (wdExpire && sdaIn) begin
          next_busFree = 1'b1;
        end else if (wdExpire) begin
          next_state = REC_LOW;
        end
      end
      REC_LOW: begin
        if (halfCnt == HW'(SCL_HALF - 1)) begin
          next_halfCnt = '0;
          next_state = REC_HIGH;
        end else begin
          next_halfCnt = halfCnt + HW'(1);
        end
      end
      REC_HIGH: begin
        if (halfCnt == HW'(SCL_HALF - 1)) begin
          next_halfCnt = '0;
          next_pulseCnt = pulseCnt + 4'h1;
          if (pulseCnt == 4'(`GIC_RECOVER_PULSES - 1)) begin
            next_state = REC_IDLE;
          end else begin
            next_state = REC_LOW;
          end
        end else begin
          next_halfCnt = halfCnt + HW'(1);
        end
      end
      default: begin
        next_state = REC_IDLE;
      end
    endcase
    next_sclOe = next_state == REC_LOW;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= REC_IDLE;
      wdCnt <= '0;
      halfCnt <= '0;
      pulseCnt <= 4'h0;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
      busFree <= 1'b0;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      state <= next_state;
      wdCnt <= next_wdCnt;
      halfCnt <= next_halfCnt;
      pulseCnt <= next_pulseCnt;
      sclPrev <= sclIn;
      sdaPrev <= sdaIn;
      sclOe <= next_sclOe;
      sdaOe <= next_sdaOe;
      busFree <= next_busFree;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

  // Check helpers: length of each SCL low phase and pulses per recovery
  logic [HW-1:0] lowRun, next_lowRun;
  logic [3:0] pulseSeen, next_pulseSeen;
  logic sclOePrev;

  always_comb begin
    next_lowRun = sclOe ? lowRun + HW'(1) : '0;
    if (wdExpire) begin
      next_pulseSeen = 4'h0;
    end else if (sclOePrev && !sclOe) begin
      next_pulseSeen = pulseSeen + 4'h1;
    end else begin
      next_pulseSeen = pulseSeen;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lowRun <= '0;
      pulseSeen <= 4'h0;
      sclOePrev <= 1'b0;
    end else begin
      lowRun <= next_lowRun;
      pulseSeen <= next_pulseSeen;
      sclOePrev <= sclOe;
    end
  end

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  chk_pin_local: assert property (
    pinCfg.p3En && !pinCfg.pin_three_dir && !pinCfg.pin_three_far_ctrl
    |=> pinOe[1] && pinOut[1] == $past(pinCfg.p3Val))
    else $error("pin three local value not driven");

  chk_pin_input: assert property (
    !pinCfg.pin_three_far_ctrl && pinCfg.pin_three_dir |=> !pinOe[1])
    else $error("pin three driven while set as input");

  chk_pin_tri: assert property (
    !pinCfg.p2En |=> !pinOe[0])
    else $error("pin two driven while disabled");

  chk_pin_far: assert property (
    pinCfg.p2En && pinCfg.pin_two_far_ctrl
    |=> pinOe[0] && pinOut[0] == $past(farPinVal[0]))
    else $error("pin two does not follow far value");

  chk_far_ignore: assert property (
    !pinCfg.pin_two_far_ctrl && $stable(pinCfg) |=> $stable(pinOut[0]))
    else $error("far value leaked onto pin two");

  chk_sda_min: assert property (
    $rose(mstSdaLow) && setup.sdaDelay == 2'b00 |-> ##35 sdaOe)
    else $error("SDA delay for code 00 wrong");

  chk_sda_max: assert property (
    $rose(mstSdaLow) && setup.sdaDelay == 2'b11 |-> ##50 sdaOe)
    else $error("SDA delay for code 11 wrong");

  chk_far_block: assert property (
    req.wr && req.far && setup.blockFarWr
    |=> regWrRejected && pinCfg == $past(pinCfg) && setup == $past(setup))
    else $error("far write not blocked");

  chk_slave_pass: assert property (
    farSlaveReq |=> farSlaveFwd)
    else $error("far slave access not forwarded");

  chk_wd_limit: assert property (
    wdExpire |-> wdCnt == (setup.wdFast ? CW'(WD_FAST - 1) : CW'(WD_SLOW - 1)))
    else $error("watchdog expired at wrong count");

  chk_wd_off: assert property (
    setup.wdOff |=> wdCnt == '0 && !wdExpire)
    else $error("watchdog runs while disabled");

  chk_bus_free: assert property (
    wdExpire && sdaIn |=> busFree && state == REC_IDLE)
    else $error("bus not marked free");

  chk_recover_go: assert property (
    wdExpire && !sdaIn |=> sclOe && state == REC_LOW && pulseCnt == 4'h0)
    else $error("recovery did not pull SCL low");

  chk_scl_low_len: assert property (
    $fell(sclOe) |-> lowRun == HW'(SCL_HALF))
    else $error("recovery SCL low phase has wrong length");

  chk_pulse_count: assert property (
    state == REC_HIGH ##1 state == REC_IDLE |-> pulseSeen == 4'(`GIC_RECOVER_PULSES))
    else $error("recovery did not send nine SCL pulses");

  chk_rsvd_zero: assert property (
    req.rd && req.addr == `GIC_ADDR_I2C |=> regRdData[7:5] == 3'h0)
    else $error("reserved bits not zero");

  cov_recover: cover property (wdExpire && !sdaIn);
  cov_free: cover property ($rose(busFree));
  cov_reject: cover property (regWrRejected);
  cov_far_pin: cover property (pinCfg.pin_three_far_ctrl && pinOe[1]);
endmodule : gic_gpio_i2c_cfg

// File: design/gic_pkg.sv
// Types for the pin and I2C setup block
package gic_pkg;

  typedef struct packed {
    logic p3Val;
    logic pin_three_far_ctrl;
    logic pin_three_dir;
    logic p3En;
    logic p2Val;
    logic pin_two_far_ctrl;
    logic rsvd;
    logic p2En;
  } gic_pins_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic [1:0] sdaDelay;
    logic blockFarWr;
    logic wdFast;
    logic wdOff;
  } gic_i2c_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic far;
    logic [7:0] addr;
    logic [7:0] wrData;
  } gic_req_t;

  typedef enum logic [2:0] {
    REC_IDLE = 3'b001,
    REC_LOW = 3'b010,
    REC_HIGH = 3'b100
  } gic_rec_t;

endpackage : gic_pkg

// File: design/gic_sda_delay.sv
// Programmable delay line for the SDA drive request
`timescale 1ns/1ps
`include "gic_defs.svh"
module gic_sda_delay #(
  parameter int BASE = `GIC_SDA_BASE_CYC,
  parameter int STEP = `GIC_SDA_STEP_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic din,
  input wire logic [1:0] sel,
  output logic dout
);
  localparam int DEPTH = BASE + 3 * STEP;
  logic [DEPTH-1:0] line;
  logic [DEPTH-1:0] next_line;
  int tap;

  always_comb begin
    next_line = {line[DEPTH-2:0], din};
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      line <= '0;
    end else begin
      line <= next_line;
    end
  end

  // Tap k delays by k+1 cycles; the caller's output flop adds one more
  always_comb begin
    tap = BASE - 2 + STEP * int'(sel);
    dout = line[tap];
  end
endmodule : gic_sda_delay

// File: dv/gic_bus_model.sv
// Local I2C bus with pull-ups and a slave that can hang SDA low
`timescale 1ns/1ps
module gic_bus_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic holdSdaLow,
  output logic sclIn,
  output logic sdaIn,
  output int sclRises
);
  logic sclQ;
  // Open-drain wires: released lines go to the pull-up level
  assign sclIn = ~sclOe;
  assign sdaIn = ~(sdaOe | holdSdaLow);
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclQ <= 1'b1;
      sclRises <= 0;
    end else begin
      sclQ <= sclIn;
      if (sclIn && !sclQ) sclRises <= sclRises + 1;
    end
  end
endmodule : gic_bus_model

// File: dv/tb_gpio_and_i2c_master_config.sv
// Self-checking bench for the pin and I2C setup block
`timescale 1ns/1ps
module tb_gpio_and_i2c_master_config;
  import gic_pkg::*;
  localparam int WDF = 8;
  localparam int WDS = 40;
  localparam int HALF = 4;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  gic_req_t req = '0;
  logic [7:0] regRdData;
  logic regWrRejected, sclOut, sclOe, sdaOut, sdaOe, busFree, sclIn, sdaIn, farSlaveFwd;
  logic [1:0] farPinVal = 2'h0;
  logic [1:0] pinOut, pinOe;
  logic farSlaveReq = 1'b0;
  logic mstSdaLow = 1'b0;
  logic holdSdaLow = 1'b0;
  logic rdD = 1'b0;
  int sclRises, n, base;
  int miscompares = 0;
  int tests_run = 0;
  integer seed = 32'hFF1AD9C0;
  logic [7:0] expQ[$];
  logic [7:0] d;
  logic [1:0] f;

  gic_gpio_i2c_cfg #(.WD_FAST(WDF), .WD_SLOW(WDS), .SCL_HALF(HALF)) dut_u (
    .clock(clock), .rstn(rstn), .req(req), .regRdData(regRdData),
    .regWrRejected(regWrRejected), .farPinVal(farPinVal), .pinOut(pinOut), .pinOe(pinOe),
    .farSlaveReq(farSlaveReq), .farSlaveFwd(farSlaveFwd), .mstSdaLow(mstSdaLow),
    .sclIn(sclIn), .sdaIn(sdaIn), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .busFree(busFree));
  gic_bus_model model_u (
    .clock(clock), .rstn(rstn), .sclOe(sclOe), .sdaOe(sdaOe), .holdSdaLow(holdSdaLow),
    .sclIn(sclIn), .sdaIn(sdaIn), .sclRises(sclRises));

  initial begin
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic finish_test();
    if (expQ.size() != 0) begin
      miscompares++;
      $display("MISMATCH %0t %0d reads never answered", $time, expQ.size());
    end
    $display("TB: checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic timeout();
    check(8'h00, 8'h01, "timeout");
    finish_test();
  endtask : timeout

  task automatic wr(input logic far, input logic [7:0] a, input logic [7:0] v, input logic rej);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, far: far, addr: a, wrData: v};
    @(posedge clock);
    req.wr <= 1'b0;
    @(negedge clock);
    check({7'h00, regWrRejected}, {7'h00, rej}, "reject");
  endtask : wr

  // Read request; the monitor compares the answer against the oldest note
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, far: 1'b0, addr: a, wrData: 8'h00};
    expQ.push_back(e);
    @(posedge clock);
    req.rd <= 1'b0;
  endtask : rd

  always @(posedge clock) rdD <= req.rd;
  always @(negedge clock) begin
    if (rdD && expQ.size() > 0) begin
      check(regRdData, expQ.pop_front(), "read");
    end
  end

  // Activity on SDA, then measure quiet cycles until the bus is seen free
  task automatic wd_run(input logic [7:0] cfg, input int lo, input int hi);
    wr(1'b0, 8'h0F, cfg, 1'b0);
    @(posedge clock);
    holdSdaLow <= 1'b1;
    @(posedge clock);
    holdSdaLow <= 1'b0;
    repeat (2) @(posedge clock);
    n = 0;
    while (busFree !== 1'b1 && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
    check({7'h00, n >= lo && n <= hi}, 8'h01, "watchdog");
  endtask : wd_run

  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rd(8'h0E, 8'h35);
    rd(8'h0F, 8'h00);
    rd(8'h33, 8'h00);
    wr(1'b0, 8'h0F, 8'hFF, 1'b0);
    rd(8'h0F, 8'h1F);
    wr(1'b0, 8'h0F, 8'h05, 1'b0);
    wr(1'b1, 8'h0E, 8'h00, 1'b1);
    rd(8'h0E, 8'h35);
    @(posedge clock);
    farSlaveReq <= 1'b1;
    @(posedge clock);
    farSlaveReq <= 1'b0;
    @(negedge clock);
    check({7'h00, farSlaveFwd}, 8'h01, "forward");
    wr(1'b0, 8'h0F, 8'h01, 1'b0);
    wr(1'b1, 8'h0E, 8'h14, 1'b0);
    rd(8'h0E, 8'h14);
    $display("TB: register test done");
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      f = $random(seed);
      wr(1'b0, 8'h0E, d, 1'b0);
      @(posedge clock);
      farPinVal <= f;
      repeat (2) @(posedge clock);
      @(negedge clock);
      check({6'h00, pinOe}, {6'h00, d[4] & (d[6] | ~d[5]), d[0]}, "oe");
      if (d[0]) check({7'h00, pinOut[0]}, {7'h00, d[2] ? f[0] : d[3]}, "p2");
      if (d[4] & (d[6] | ~d[5])) check({7'h00, pinOut[1]}, {7'h00, d[6] ? f[1] : d[7]}, "p3");
      rd(8'h0E, d & 8'hFD);
    end
    $display("TB: pin test done");
    for (int c = 0; c < 4; c++) begin
      wr(1'b0, 8'h0F, {3'h0, c[1:0], 3'h1}, 1'b0);
      @(posedge clock);
      mstSdaLow <= 1'b1;
      n = 0;
      while (sdaOe !== 1'b1) begin
        @(posedge clock);
        #1;
        n++;
        if (n > 80) timeout();
      end
      check({7'h00, n >= 33 + 5 * c && n <= 37 + 5 * c}, 8'h01, "sda delay");
      check({6'h00, sclOut, sdaOut}, 8'h00, "open drain");
      @(posedge clock);
      mstSdaLow <= 1'b0;
      repeat (60) @(posedge clock);
    end
    $display("TB: sda delay test done");
    wd_run(8'h02, WDF - 2, WDF + 3);
    wd_run(8'h00, WDS - 2, WDS + 3);
    wd_run(8'h03, 100, 100);
    wr(1'b0, 8'h0F, 8'h02, 1'b0);
    @(posedge clock);
    holdSdaLow <= 1'b1;
    n = 0;
    while (sclOe !== 1'b1) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 40) timeout();
    end
    base = sclRises;
    repeat (2 * HALF * 9 + 2) @(posedge clock);
    check(8'(sclRises - base), 8'h09, "recovery");
    check({7'h00, busFree}, 8'h00, "held low");
    holdSdaLow <= 1'b0;
    $display("TB: watchdog test done");
    finish_test();
  end
endmodule : tb_gpio_and_i2c_master_config
